// >>> alert_qual_defines.svh
// constants for the temperature alert qualifier
`ifndef ALERT_QUAL_DEFINES_SVH
`define ALERT_QUAL_DEFINES_SVH
// register byte addresses, one aligned word each; byte address is four times the index
`define IDX_COUNT_SETTING   8'h22
`define OFS_COUNT_SETTING   8'h88
`define OFS_CONTROL         8'h00
`define OFS_HOT_SELECT      8'h04
`define OFS_HOT_TEMP        8'h08
`define OFS_HOT_STATUS      8'h0C
`define OFS_HIGH_STATUS     8'h10
`define OFS_LOW_STATUS      8'h14
`define OFS_FAULT_STATUS    8'h18
`define OFS_OVERTEMP_STATUS 8'h1C
`define OFS_PIN_STATUS      8'h20
`define OFS_ATTN_MASK       8'h24
`define OFS_HYSTERESIS      8'h28
// count setting fields
`define ATTN_FIELD_LSB      0
`define OVER_FIELD_LSB      4
`define ATTN_FIELD_RESET    3'h0
`define OVER_FIELD_RESET    3'h7
// control bits and hysteresis reset value
`define CTRL_COMPARATOR_BIT 0
`define CTRL_TRACK_HOT_BIT  1
`define HYST_RESET          8'h0A
// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// >>> alert_qual_pkg.sv
// types for the temperature alert qualifier
package alert_qual_pkg;
  // one channel's measurement as delivered by the converter
  typedef struct packed {
    logic       above_high;
    logic       below_low;
    logic       fault;
    logic       above_over;
    logic       below_over_hyst;
    logic       below_high_hyst;
    logic [7:0] temp;
  } chan_meas_t;
  // count decoding result
  typedef enum logic [2:0] {
    need_one   = 3'b000,
    need_two   = 3'b001,
    need_three = 3'b011,
    need_four  = 3'b111
  } count_code_t;
  // register bus slave states
  typedef enum logic [2:0] {
    bus_idle  = 3'b001,
    bus_wresp = 3'b010,
    bus_rresp = 3'b100
  } bus_state_t;
endpackage

// >>> consec_counter.sv
// per-channel consecutive measurement counter
`timescale 1ns/1ns
`default_nettype none
module consec_counter (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // measurement qualification
  input  wire logic       update,
  input  wire logic       enable,
  input  wire logic       condition,
  input  wire logic       release_ok,
  input  wire logic       sticky,
  input  wire logic [2:0] need,
  // result
  output logic            fire,
  output logic            held
);
  logic [2:0] count;
  wire  [2:0] count_inc = count + 3'h1;
  wire        reach     = condition && (count_inc >= need);

  assign fire = update && enable && reach;
  // a sticky counter stays at its target until the release threshold is crossed
  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= 3'h0;
      held  <= 1'b0;
    end else if (update && enable) begin
      if (held) begin
        if (release_ok) begin
          count <= 3'h0;
          held  <= 1'b0;
        end
      end else if (reach) begin
        count <= sticky ? need : 3'h0;
        held  <= sticky;
      end else if (condition) begin
        count <= count_inc;
      end else begin
        count <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hottest_select.sv
// hottest channel comparator
`timescale 1ns/1ns
`default_nettype none
module hottest_select #(
  parameter int NCH = 5
) (
  // channel temperatures and selection
  input  wire logic [NCH*8-1:0] temps,
  input  wire logic [NCH-1:0]   sel,
  // result
  output logic      [7:0]       hot_temp,
  output logic      [NCH-1:0]   hot_flags
);
  wire  [7:0] running [NCH:0];
  assign running[0] = 8'h00;
  genvar i;
  // running maximum over selected channels
  generate
    for (i = 0; i < NCH; i++) begin : g_max
      wire [7:0] t = temps[i*8 +: 8];
      assign running[i+1] = (sel[i] && t > running[i]) ? t : running[i];
      assign hot_flags[i] = sel[i] && (t == running[NCH]);
    end
  endgenerate
  assign hot_temp = running[NCH];
endmodule
`default_nettype wire

// >>> temp_alert_qualifier.sv
// alert qualification logic with axi4-lite register access
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "alert_qual_defines.svh"
// Functional notes
// [RL1] each channel has separate attention and over-temperature counters
// [RL2] attention counter steps on consecutive high, low or fault conditions
// [RL3] attention counter clears on a measurement with no error
// [RL4] interrupt mode: at count set status and flags, pulse pin, clear counter; the code latches the pin until software clears it
// [RL5] comparator mode: attention counter counts only high-limit excursions
// [RL6] comparator mode: pin and counter hold until below high minus hysteresis
// [RL7] comparator mode: low and fault set status at once, pin untouched
// [RL8] disabled channels are skipped by all counting
// [RL9] order is limit, counter, status, mask, pin for both pins; the over-temperature pin has no mask stage in the code
// [RL10] firing channel alone gets status and counter reset
// [RL11] over-temperature counter steps above the over-temperature limit
// [RL12] before assertion the over-temperature counter clears below the limit
// [RL13] over-temperature pin goes low after programmed consecutive excursions
// [RL14] after assertion it releases only below limit minus hysteresis
// [RL15] count code 000,001,011,111 means 1,2,3,4 measurements
// [RL16] reset selects one for attention and four for over-temperature
// [RL17] one count setting shared by all channels of a pin type
// [RL18] undefined count codes are ignored, previous setting kept
// [RL19] each cycle the hottest selected channel is recorded with status
// [RL20] ties set hottest status for every tied channel
// [RL21] tracking enabled: hottest change flags event and may raise attention
// [RL22] diode open or supply short counts as a fault
// [RL23] all results update once per completed conversion
module temp_alert_qualifier #(
  parameter int NCH = 5
) (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           srst,
  // measurement inputs
  input  wire logic                           meas_done,
  input  wire logic [NCH-1:0]                 chan_enable,
  input  wire alert_qual_pkg::chan_meas_t [NCH-1:0] meas,
  input  wire logic [NCH-1:0]                 diode_open,
  input  wire logic [NCH-1:0]                 diode_supply_short,
  // pins, open drain: enable low means driving low
  output logic                                attention_n_o,
  output logic                                attention_n_oe,
  output logic                                overtemp_n_o,
  output logic                                overtemp_n_oe,
  // axi4-lite write address and data
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [7:0]                     awaddr,
  input  wire logic                           wvalid,
  output logic                                wready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  // axi4-lite write response
  output logic                                bvalid,
  input  wire logic                           bready,
  output logic [1:0]                          bresp,
  // axi4-lite read
  input  wire logic                           arvalid,
  output logic                                arready,
  input  wire logic [7:0]                     araddr,
  output logic                                rvalid,
  input  wire logic                           rready,
  output logic [31:0]                         rdata,
  output logic [1:0]                          rresp
);
  // registers
  logic [2:0]     attn_need_code;
  logic [2:0]     over_need_code;
  logic [1:0]     control;
  logic [NCH-1:0] hot_select;
  logic [NCH-1:0] attn_mask;
  logic [7:0]     hysteresis;
  logic [7:0]     hot_temp;
  logic [NCH-1:0] hot_status;
  logic [NCH-1:0] prev_hot;
  logic           hot_changed;
  logic [NCH-1:0] high_status;
  logic [NCH-1:0] low_status;
  logic [NCH-1:0] fault_status;
  logic [NCH-1:0] over_status;
  logic           attn_int;
  logic           meas_seen;
  alert_qual_pkg::bus_state_t bus_state;
  logic [7:0]     wr_addr;
  logic [31:0]    wr_data;
  logic [3:0]     wr_strb;
  logic           have_aw;
  logic           have_w;
  wire            clear_attn;

  wire comparator = control[`CTRL_COMPARATOR_BIT];
  wire track_hottest_change = control[`CTRL_TRACK_HOT_BIT];

  // count code decode to number of measurements
  function automatic logic [2:0] decode_need(input logic [2:0] code);
    case (code)
      3'b000:  decode_need = 3'h1;
      3'b001:  decode_need = 3'h2;
      3'b011:  decode_need = 3'h3;
      3'b111:  decode_need = 3'h4;
      default: decode_need = 3'h1;
    endcase
  endfunction
  function automatic logic code_valid(input logic [2:0] code);
    code_valid = (code == 3'b000) || (code == 3'b001) || (code == 3'b011) ||
                 (code == 3'b111);
  endfunction

  wire [2:0] attn_need = decode_need(attn_need_code); // [RL15] [RL17]
  wire [2:0] over_need = decode_need(over_need_code); // [RL15] [RL17]

  // per-channel counters, one pair per channel
  wire [NCH-1:0] attn_fire;
  wire [NCH-1:0] attn_held;
  wire [NCH-1:0] over_fire;
  wire [NCH-1:0] over_held;
  wire [NCH-1:0] fault_now;
  wire [NCH-1:0] attn_cond;
  wire [NCH-1:0] low_now, high_now;
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_chan
      // open or supply short on the diode pins is a fault
      assign fault_now[i] = meas[i].fault || diode_open[i] || diode_supply_short[i]; // [RL22]
      assign low_now[i]   = meas[i].below_low;
      assign high_now[i]  = meas[i].above_high;
      // comparator mode counts only high-limit excursions
      assign attn_cond[i] = comparator ? meas[i].above_high :
                            (meas[i].above_high || meas[i].below_low || fault_now[i]); // [RL2] [RL3] [RL5]
      consec_counter u_attn ( // [RL1]
        .mclk       (mclk),
        .srst       (srst),
        .update     (meas_done),
        .enable     (chan_enable[i]), // [RL8]
        .condition  (attn_cond[i]),
        .release_ok (meas[i].below_high_hyst),
        .sticky     (comparator),
        .need       (attn_need),
        .fire       (attn_fire[i]),
        .held       (attn_held[i])
      );
      consec_counter u_over ( // [RL1] [RL11] [RL12] [RL14]
        .mclk       (mclk),
        .srst       (srst),
        .update     (meas_done),
        .enable     (chan_enable[i]),
        .condition  (meas[i].above_over),
        .release_ok (meas[i].below_over_hyst),
        .sticky     (1'b1),
        .need       (over_need),
        .fire       (over_fire[i]),
        .held       (over_held[i])
      );
    end
  endgenerate

  // hottest comparison on the current measurement set
  wire [NCH*8-1:0] temps_flat;
  wire [7:0]       next_hot_temp;
  wire [NCH-1:0]   next_hot_flags;
  generate
    for (i = 0; i < NCH; i++) begin : g_temp
      assign temps_flat[i*8 +: 8] = meas[i].temp;
    end
  endgenerate
  hottest_select #(.NCH(NCH)) u_hot (
    .temps     (temps_flat),
    .sel       (hot_select & chan_enable),
    .hot_temp  (next_hot_temp),
    .hot_flags (next_hot_flags)
  );
  wire hot_change_evt = meas_seen && (next_hot_flags != prev_hot); // [RL21]

  // status capture; interrupt-mode statuses are sticky, only the firing channel sets
  wire [NCH-1:0] en_low   = chan_enable & {NCH{comparator}};
  wire [NCH-1:0] set_high = attn_fire & {NCH{1'b1}};
  wire [NCH-1:0] set_low  = comparator ? (en_low & low_now) : (attn_fire & low_now);
  wire [NCH-1:0] set_flt  = comparator ? (en_low & fault_now) : (attn_fire & fault_now);

  // status, mask and pin: mask gates only the pin, never the status
  wire attn_comp_level = |((attn_held | attn_fire) & ~attn_mask);
  wire attn_event = meas_done && ((!comparator && |(set_high & high_now & ~attn_mask)) ||
                    |(set_low & ~en_low & ~attn_mask) || |(set_flt & ~en_low & ~attn_mask) ||
                    (track_hottest_change && hot_change_evt)); // [RL9] [RL4] [RL7] [RL6]
  wire over_level = |(over_held | over_fire); // [RL13]

  always_ff @(posedge mclk) begin
    if (srst) begin
      high_status  <= '0;
      low_status   <= '0;
      fault_status <= '0;
      over_status  <= '0;
    end else if (meas_done) begin // [RL23]
      high_status  <= high_status  | (set_high & high_now);   // [RL4] [RL10]
      low_status   <= low_status   | set_low;                 // [RL7]
      fault_status <= fault_status | set_flt;
      over_status  <= over_status  | over_fire;
    end
  end

  // hottest record and change flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      hot_temp    <= 8'h00;
      hot_status  <= '0;
      prev_hot    <= '0;
      meas_seen   <= 1'b0;
      hot_changed <= 1'b0;
    end else if (meas_done) begin
      hot_temp    <= next_hot_temp;  // [RL19]
      hot_status  <= next_hot_flags; // [RL20]
      prev_hot    <= next_hot_flags;
      meas_seen   <= 1'b1;
      hot_changed <= hot_changed | (track_hottest_change && hot_change_evt); // [RL21]
    end
  end

  // pin drive: interrupt mode latches until software clears it, comparator follows level
  always_ff @(posedge mclk) begin
    if (srst) begin
      attn_int       <= 1'b0;
      attention_n_oe <= 1'b1;
      overtemp_n_oe  <= 1'b1;
      attention_n_o  <= 1'b0;
      overtemp_n_o   <= 1'b0;
    end else begin
      if (attn_event) attn_int <= 1'b1;
      else if (clear_attn) attn_int <= 1'b0;
      attention_n_oe <= ~((comparator && attn_comp_level) || attn_int); // [RL6]
      overtemp_n_oe  <= ~over_level;                                   // [RL13]
      attention_n_o  <= 1'b0; // open drain: only the enables ever move
      overtemp_n_o   <= 1'b0;
    end
  end

  // axi4-lite write: address and data taken in either order
  wire do_write  = have_aw && have_w && (bus_state == alert_qual_pkg::bus_idle);
  wire hit_count = wr_addr == `OFS_COUNT_SETTING;
  wire [2:0] new_attn = wr_data[`ATTN_FIELD_LSB +: 3];
  wire [2:0] new_over = wr_data[`OVER_FIELD_LSB +: 3];
  wire known_wr = hit_count || wr_addr == `OFS_CONTROL || wr_addr == `OFS_HOT_SELECT ||
                  wr_addr == `OFS_ATTN_MASK || wr_addr == `OFS_HYSTERESIS;
  assign clear_attn = do_write && wr_addr == `OFS_PIN_STATUS && wr_strb[0];
  always_ff @(posedge mclk) begin
    if (srst) begin
      have_aw <= 1'b0;
      have_w  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        have_aw <= 1'b1;
        wr_addr <= awaddr;
      end else if (do_write) have_aw <= 1'b0;
      if (wvalid && wready) begin
        have_w  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (do_write) have_w <= 1'b0;
    end
  end
  assign awready = ~have_aw;
  assign wready  = ~have_w;

  // register updates; undefined count codes leave the field alone
  always_ff @(posedge mclk) begin
    if (srst) begin
      attn_need_code <= `ATTN_FIELD_RESET; // [RL16]
      over_need_code <= `OVER_FIELD_RESET; // [RL16]
      control        <= 2'h0;
      hot_select     <= '1;
      attn_mask      <= '0;
      hysteresis     <= `HYST_RESET;
    end else if (do_write && wr_strb[0]) begin
      if (hit_count && code_valid(new_attn)) attn_need_code <= new_attn; // [RL18]
      if (hit_count && code_valid(new_over)) over_need_code <= new_over; // [RL18]
      if (wr_addr == `OFS_CONTROL)    control    <= wr_data[1:0];
      if (wr_addr == `OFS_HOT_SELECT) hot_select <= wr_data[NCH-1:0];
      if (wr_addr == `OFS_ATTN_MASK)  attn_mask  <= wr_data[NCH-1:0];
      if (wr_addr == `OFS_HYSTERESIS) hysteresis <= wr_data[7:0];
    end
  end

  // read data mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr)
      `OFS_COUNT_SETTING:   rd_word = {24'h00_0000, 1'b0, over_need_code, 1'b0, attn_need_code};
      `OFS_CONTROL:         rd_word = {30'h0, control};
      `OFS_HOT_SELECT:      rd_word[NCH-1:0] = hot_select;
      `OFS_HOT_TEMP:        rd_word[7:0] = hot_temp;
      `OFS_HOT_STATUS:      rd_word = {23'h0, hot_changed, 8'h00} | 32'(hot_status);
      `OFS_HIGH_STATUS:     rd_word[NCH-1:0] = high_status;
      `OFS_LOW_STATUS:      rd_word[NCH-1:0] = low_status;
      `OFS_FAULT_STATUS:    rd_word[NCH-1:0] = fault_status;
      `OFS_OVERTEMP_STATUS: rd_word[NCH-1:0] = over_status;
      `OFS_PIN_STATUS:      rd_word[1:0] = {~overtemp_n_oe, ~attention_n_oe};
      `OFS_ATTN_MASK:       rd_word[NCH-1:0] = attn_mask;
      `OFS_HYSTERESIS:      rd_word[7:0] = hysteresis;
      default:              rd_word = 32'h0000_0000;
    endcase
  end
  wire rd_known = (araddr <= `OFS_HYSTERESIS && araddr[1:0] == 2'b00) ||
                  araddr == `OFS_COUNT_SETTING;

  // response channel state machine
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_state <= alert_qual_pkg::bus_idle;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= `RESP_OKAY;
    end else begin
      case (bus_state)
        alert_qual_pkg::bus_idle: begin
          if (do_write) begin
            bvalid    <= 1'b1;
            bresp     <= (known_wr || wr_addr == `OFS_PIN_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
            bus_state <= alert_qual_pkg::bus_wresp;
          end else if (arvalid) begin
            rvalid    <= 1'b1;
            rdata     <= rd_word;
            rresp     <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
            bus_state <= alert_qual_pkg::bus_rresp;
          end
        end
        alert_qual_pkg::bus_wresp: begin
          if (bready) begin
            bvalid    <= 1'b0;
            bus_state <= alert_qual_pkg::bus_idle;
          end
        end
        alert_qual_pkg::bus_rresp: begin
          if (rready) begin
            rvalid    <= 1'b0;
            bus_state <= alert_qual_pkg::bus_idle;
          end
        end
        default: bus_state <= alert_qual_pkg::bus_idle;
      endcase
    end
  end
  assign arready = (bus_state == alert_qual_pkg::bus_idle) && !do_write;

  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  count_reject_a: assert property (do_write && hit_count && !code_valid(new_attn) // [RL18]
    |=> $stable(attn_need_code)) else $error("undefined attention code accepted");
  over_pin_a: assert property (meas_done && |over_fire |=> !overtemp_n_oe) // [RL13]
    else $error("over-temperature pin not driven");
  status_only_a: assert property (!meas_done |=> $stable(high_status)) // [RL23]
    else $error("status moved without measurement");
  ov_hold_a: assert property ($rose(overtemp_n_oe) |-> $past(meas_done, 2)) // [RL14]
    else $error("over-temperature pin released without a measurement");
  cmp_low_a: assert property (meas_done && comparator && |(chan_enable & low_now) // [RL7]
    |=> |low_status) else $error("low status missing in comparator mode");
  hot_rec_a: assert property (meas_done |=> hot_temp == $past(next_hot_temp)) // [RL19]
    else $error("hottest temperature not recorded");
  int_pin_a: assert property (meas_done && !comparator && // [RL4]
    |(attn_fire & high_now & ~attn_mask) |=> ##1 !attention_n_oe)
    else $error("attention pin missing");
  reset_code_a: assert property ($fell(srst) |-> attn_need_code == `ATTN_FIELD_RESET && // [RL16]
    over_need_code == `OVER_FIELD_RESET) else $error("count fields not at reset values");
  cov_attn: cover property (!attention_n_oe);
  cov_over: cover property (!overtemp_n_oe);
  cov_hot:  cover property (hot_changed);
endmodule
`default_nettype wire

// >>> host_pin_monitor.sv
// host side model that watches the two open-drain alarm pins
`timescale 1ns/1ns
`default_nettype none
module host_pin_monitor (
  // pin drivers from the device
  input  wire logic attention_n_o,
  input  wire logic attention_n_oe,
  input  wire logic overtemp_n_o,
  input  wire logic overtemp_n_oe,
  // levels seen by the host
  output logic      attention_lvl,
  output logic      overtemp_lvl
);
  // board pull-ups: a released pin reads high, never the last driven value
  assign attention_lvl = attention_n_oe ? 1'b1 : attention_n_o;
  assign overtemp_lvl  = overtemp_n_oe ? 1'b1 : overtemp_n_o;
endmodule
`default_nettype wire

// >>> temp_alert_qualifier_tb.sv
// self-checking bench for the temperature alert qualifier
`timescale 1ns/1ns
`default_nettype none
`include "alert_qual_defines.svh"
module temp_alert_qualifier_tb;
  localparam int NCH = 5;
  localparam logic [5:0] HI = 6'h20, LO = 6'h10, FT = 6'h08, OV = 6'h04, OH = 6'h02, HH = 6'h01;
  logic                                 mclk, srst, meas_done, att, ovt;
  logic                                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                                 arvalid, arready, rvalid, rready;
  logic                                 attention_n_o, attention_n_oe, overtemp_n_o, overtemp_n_oe;
  logic [NCH-1:0]                       chan_enable, diode_open, diode_supply_short;
  alert_qual_pkg::chan_meas_t [NCH-1:0] meas;
  logic [7:0]                           awaddr, araddr;
  logic [31:0]                          wdata, rdata, rd;
  logic [3:0]                           wstrb;
  logic [1:0]                           bresp, rresp, rr;
  logic [7:0]                           tv [NCH];
  logic [2:0]                           codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  int                                   num_errors, total_checks, n, ch;

  temp_alert_qualifier #(.NCH(NCH)) DUT (.*);
  host_pin_monitor host (.attention_n_o, .attention_n_oe, .overtemp_n_o, .overtemp_n_oe,
                         .attention_lvl(att), .overtemp_lvl(ovt));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask

  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // write: both channels offered together, each dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int   k;
    k  = 0;
    tb = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!tb && k < 100) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rr = bresp;
      k++;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(negedge mclk);
    if (!tb) num_errors++;
  endtask

  // read: values sampled mid-cycle equal what the next edge samples
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int   k;
    k  = 0;
    tr = 1'b0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!tr && k < 100) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      k++;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tr) num_errors++;
  endtask

  // one measurement: flags on channel c, temperatures from tv, pins settled on return
  task automatic ms(input int c, input logic [5:0] f);
    alert_qual_pkg::chan_meas_t [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) m[i].temp = tv[i];
    m[c] = {f, tv[c]};
    @(posedge mclk);
    meas      <= m;
    meas_done <= 1'b1;
    @(posedge mclk);
    meas_done <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  function automatic int need_of(input logic [2:0] c);
    case (c)
      3'h0:    need_of = 1;
      3'h1:    need_of = 2;
      3'h3:    need_of = 3;
      default: need_of = 4;
    endcase
  endfunction

  function automatic logic [7:0] hot_max();
    hot_max = 8'h00;
    foreach (tv[i]) if (tv[i] > hot_max) hot_max = tv[i];
  endfunction

  function automatic logic [NCH-1:0] hot_bits();
    foreach (tv[i]) hot_bits[i] = (tv[i] == hot_max());
  endfunction

  // main sequence
  initial begin
    void'($urandom(32'h8f7f));
    srst = 1'b1;
    {meas_done, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, meas, diode_open, diode_supply_short} = '0;
    wstrb       = 4'hF;
    chan_enable = '1;
    foreach (tv[i]) tv[i] = 8'h00;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd_reg(`OFS_COUNT_SETTING, rd, rr);
    chk_reg(rd & 32'h0000_0077, 32'h0000_0070);
    wr(`OFS_COUNT_SETTING, 32'h0000_0025);
    rd_reg(`OFS_COUNT_SETTING, rd, rr);
    chk_reg(rd & 32'h0000_0077, 32'h0000_0070);
    rd_reg(8'hFC, rd, rr);
    chk_reg({30'h0, rr}, {30'h0, `RESP_SLVERR});
    wr(8'hFC, 32'h0000_0000);
    chk_reg({30'h0, rr}, {30'h0, `RESP_SLVERR});
    wr(`OFS_ATTN_MASK, 32'h0000_0000);
    wr(`OFS_HOT_SELECT, 32'h0000_001F);
    // interrupt mode: every count code, mixed error kinds, reset and clear on fire
    foreach (codes[i]) begin
      wr(`OFS_COUNT_SETTING, {25'h0, 3'h7, 1'b0, codes[i]});
      n  = need_of(codes[i]);
      ch = $urandom_range(NCH - 1);
      repeat (n - 1) ms(ch, HI);
      ms(ch, 6'h00);
      repeat (n - 1) ms(ch, FT);
      chk_pin(att, 1'b1);
      ms(ch, HI);
      chk_pin(att, 1'b0);
      rd_reg(`OFS_HIGH_STATUS, rd, rr);
      chk_reg({31'h0, rd[ch]}, 32'h0000_0001);
      wr(`OFS_PIN_STATUS, 32'h0000_0001);
      repeat (n - 1) ms(ch, HI);
      chk_pin(att, 1'b1);
      ms(ch, 6'h00);
    end
    // diode fault from the pins, then a disabled channel
    wr(`OFS_COUNT_SETTING, 32'h0000_0070);
    wr(`OFS_PIN_STATUS, 32'h0000_0001);
    ch = $urandom_range(NCH - 1);
    @(posedge mclk);
    diode_supply_short[ch] <= 1'b1;
    ms(ch, 6'h00);
    chk_pin(att, 1'b0);
    rd_reg(`OFS_FAULT_STATUS, rd, rr);
    chk_reg({31'h0, rd[ch]}, 32'h0000_0001);
    @(posedge mclk);
    diode_supply_short[ch] <= 1'b0;
    chan_enable[ch]        <= 1'b0;
    wr(`OFS_PIN_STATUS, 32'h0000_0001);
    ms(ch, HI);
    chk_pin(att, 1'b1);
    @(posedge mclk);
    chan_enable[ch] <= 1'b1;
    // over-temperature: every count code with hysteresis release
    foreach (codes[i]) begin
      wr(`OFS_COUNT_SETTING, {25'h0, codes[i], 4'h0});
      n  = need_of(codes[i]);
      ch = $urandom_range(NCH - 1);
      repeat (n - 1) ms(ch, OV);
      ms(ch, 6'h00);
      repeat (n - 1) ms(ch, OV);
      chk_pin(ovt, 1'b1);
      ms(ch, OV);
      chk_pin(ovt, 1'b0);
      ms(ch, 6'h00);
      chk_pin(ovt, 1'b0);
      ms(ch, OH);
      chk_pin(ovt, 1'b1);
    end
    // comparator mode with a count of two
    wr(`OFS_COUNT_SETTING, 32'h0000_0071);
    wr(`OFS_PIN_STATUS, 32'h0000_0001);
    wr(`OFS_CONTROL, 32'h0000_0001);
    ch = $urandom_range(NCH - 1);
    ms(ch, LO);
    ms(ch, FT);
    chk_pin(att, 1'b1);
    rd_reg(`OFS_LOW_STATUS, rd, rr);
    chk_reg({31'h0, rd[ch]}, 32'h0000_0001);
    ms(ch, HI);
    ms(ch, HI);
    chk_pin(att, 1'b0);
    ms(ch, 6'h00);
    chk_pin(att, 1'b0);
    ms(ch, HH);
    chk_pin(att, 1'b1);
    // hottest channel with a forced tie at the maximum
    wr(`OFS_CONTROL, 32'h0000_0000);
    repeat (3) begin
      foreach (tv[i]) tv[i] = 8'($urandom);
      tv[3] = hot_max();
      ms(0, 6'h00);
      rd_reg(`OFS_HOT_TEMP, rd, rr);
      chk_reg(rd & 32'h0000_00FF, {24'h0, hot_max()});
      rd_reg(`OFS_HOT_STATUS, rd, rr);
      chk_reg(rd & 32'h0000_001F, {27'h0, hot_bits()});
    end
    // hottest-change tracking: move the maximum off channel 3, expect flag and pin
    wr(`OFS_CONTROL, 32'h0000_0002);
    wr(`OFS_PIN_STATUS, 32'h0000_0001);
    tv[1] = 8'hFF;
    tv[3] = 8'h00;
    ms(0, 6'h00);
    chk_pin(att, 1'b0);
    rd_reg(`OFS_HOT_STATUS, rd, rr);
    chk_reg(rd & 32'h0000_0100, 32'h0000_0100);
    summarize();
  end

  // watchdog: the tests need under a thousand cycles, this allows far more
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
